/* File: verilog/aom_pkg.sv */
// package for the analog output process-image mapper
// assumes one 10 MHz system clock and word-wide process-image access from the coupler
package aom_pkg;

  // ==========================================================================
  // image geometry
  localparam int CH_PER_TERM  = 4;
  localparam int IMG_BYTES    = 12;
  localparam int COMPACT_WORDS = 4;
  localparam int ALIGN_WORDS   = 8;

  // ==========================================================================
  // control and status byte fields
  localparam int CB_SEL_BIT = 7;
  localparam int CB_WR_BIT  = 6;
  localparam int CB_NUM_MSB = 5;

  // ==========================================================================
  // channel register numbers and reset values
  localparam logic [5:0]  REG_FEATURE   = 6'h20;
  localparam logic [5:0]  REG_OFFSET    = 6'h21;
  localparam logic [5:0]  REG_GAIN      = 6'h22;
  localparam logic [5:0]  REG_ACTIVATE  = 6'h23;
  localparam logic [15:0] FEATURE_RST   = 16'h0006;
  localparam logic [15:0] FEATURE_MASK  = 16'h012F;
  localparam logic [15:0] OFFSET_RST    = 16'h0000;
  localparam logic [15:0] GAIN_RST      = 16'h0100;
  localparam logic [15:0] ACTIVATE_RST  = 16'h0000;

  // ==========================================================================
  // feature bit positions
  localparam int FB_USER_SCALE = 0;
  localparam int FB_MFR_SCALE  = 1;
  localparam int FB_WDOG_RUN   = 2;
  localparam int FB_SIGN_MAG   = 3;
  localparam int FB_TWOS_COMP  = 5;
  localparam int FB_USE_ACT    = 8;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {K_CTRL, K_D0, K_D1} aom_kind_t;

  typedef struct packed {
    logic      hit;
    logic [1:0] ch;
    aom_kind_t kind;
  } aom_map_t;

  typedef struct packed {
    logic complete;
    logic big_endian;
    logic word_align;
  } aom_layout_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        term;
    logic [2:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } aom_img_req_t;

  typedef struct packed {
    logic [15:0] value;
    logic [15:0] offset;
    logic [15:0] gain;
    logic [15:0] activation;
    logic        user_scale;
    logic        mfr_scale;
    logic        wdog_run;
    logic        sign_mag;
    logic        twos_comp;
    logic        use_act;
  } aom_chan_cfg_t;

endpackage

/* File: verilog/aom_mapper.sv */
// process-image mapper and per-channel parameter set of a four-channel analog output terminal
// assumes the coupler presents word accesses synchronous to clk_sys; layout settings are static
// What this block does
// RQ1: feature bit 0 enables user scaling; cleared after reset.
// RQ2: feature bit 1 enables manufacturer scaling; set after reset.
// RQ3: feature bit 2 runs the channel watchdog; set after reset.
// RQ4: feature bit 3 selects sign-and-magnitude values; cleared after reset.
// RQ5: feature bit 5 selects two's-complement values; cleared after reset.
// RQ6: feature bit 8 enables the user activation value; cleared after reset.
// RQ7: per-channel writable user offset, zero after reset.
// RQ8: per-channel writable user gain, 256 after reset.
// RQ9: per-channel writable user activation value, zero after reset.
// RQ10: four channels use at most twelve input and twelve output bytes, or sixteen each in the aligned layout.
// RQ11: process data mode takes values from output words; input words stay unused.
// RQ12: eight channels appear as two consecutive four-channel terminals.
// RQ13: compact layout maps only four output words, no control or status.
// RQ14: value splits into low and high byte; big-endian swaps them.
// RQ15: complete unaligned layout packs control then two data bytes into six words.
// RQ16: status byte sits in the input image where the control byte sits.
// RQ17: aligned layout gives control plus pad word, then data word, eight words.
// RQ18: pad bytes hold no content; writes ignored.
// RQ19: control bit 7 selects register access, bit 6 write, bits 5..0 number.
// RQ20: status echoes the select bit and reports the register number accessed.
`timescale 1ns/1ps
module aom_mapper #(
  parameter int N_TERM = 1
) (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire aom_pkg::aom_layout_t  layout,
  input  wire aom_pkg::aom_img_req_t img_req,
  output logic [15:0]                img_rdata,
  output logic                       img_rvalid,
  output aom_pkg::aom_chan_cfg_t     chan_cfg [4*N_TERM]
);

  localparam int NCH = aom_pkg::CH_PER_TERM * N_TERM;

  // ==========================================================================
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================================
  // byte placement
  function automatic aom_pkg::aom_map_t map_byte(input logic [2:0] w,
                                                 input logic lane,
                                                 input logic is_in,
                                                 input aom_pkg::aom_layout_t lay);
    aom_pkg::aom_map_t m;
    logic [3:0]        b;
    logic [1:0]        pos;
    m    = '0;
    m.kind = aom_pkg::K_CTRL;
    b    = {w, lane};
    pos  = 2'(b % 3);
    if (!lay.complete) begin
      if (!is_in && 32'(w) < aom_pkg::COMPACT_WORDS) begin // [RQ13]
        m.hit  = 1'b1;
        m.ch   = w[1:0];
        m.kind = (lane ^ lay.big_endian) ? aom_pkg::K_D1 : aom_pkg::K_D0; // [RQ14]
      end
    end else if (lay.word_align) begin // [RQ17]
      m.ch = w[2:1];
      if (!w[0]) begin
        m.hit = !lane; // [RQ18]
      end else begin
        m.hit  = 1'b1;
        m.kind = (lane ^ lay.big_endian) ? aom_pkg::K_D1 : aom_pkg::K_D0;
      end
    end else if (32'(b) < aom_pkg::IMG_BYTES) begin // [RQ15] [RQ10]
      m.hit = 1'b1;
      m.ch  = 2'(b / 3);
      if (pos == 2'd0) begin
        m.kind = aom_pkg::K_CTRL;
      end else begin
        m.kind = ((pos == 2'd2) ^ lay.big_endian) ? aom_pkg::K_D1 : aom_pkg::K_D0;
      end
    end
    return m;
  endfunction

  aom_pkg::aom_map_t out_map [2];
  aom_pkg::aom_map_t in_map  [2];

  always_comb begin
    for (int l = 0; l < 2; l++) begin
      out_map[l] = map_byte(img_req.addr, l[0], 1'b0, layout);
      in_map[l]  = map_byte(img_req.addr, l[0], 1'b1, layout); // [RQ16]
    end
  end

  // ==========================================================================
  // per-channel state
  logic [7:0]  ctrl_q   [NCH];
  logic [7:0]  d0_q     [NCH];
  logic [7:0]  d1_q     [NCH];
  logic [7:0]  status_q [NCH];
  logic [15:0] din_q    [NCH];
  logic [15:0] value_q  [NCH];
  logic [15:0] feat_q   [NCH];
  logic [15:0] offs_q   [NCH];
  logic [15:0] gain_q   [NCH];
  logic [15:0] act_q    [NCH];
  logic        touch_q  [NCH];

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    // each terminal answers only its own image, so a second one simply extends the index
    localparam logic       TERM = 1'(g / aom_pkg::CH_PER_TERM); // [RQ12]
    localparam logic [1:0] CH   = 2'(g % aom_pkg::CH_PER_TERM);
    logic [1:0]  hit_ctrl;
    logic [1:0]  hit_d0;
    logic [1:0]  hit_d1;
    logic        reg_sel;
    logic        reg_wr;
    logic [5:0]  reg_num;
    logic [15:0] ow;
    logic [15:0] reg_rd;

    always_comb begin
      for (int l = 0; l < 2; l++) begin
        hit_ctrl[l] = img_req.wr && img_req.be[l] && img_req.term == TERM &&
                      out_map[l].hit && out_map[l].ch == CH &&
                      out_map[l].kind == aom_pkg::K_CTRL;
        hit_d0[l]   = img_req.wr && img_req.be[l] && img_req.term == TERM &&
                      out_map[l].hit && out_map[l].ch == CH &&
                      out_map[l].kind == aom_pkg::K_D0;
        hit_d1[l]   = img_req.wr && img_req.be[l] && img_req.term == TERM &&
                      out_map[l].hit && out_map[l].ch == CH &&
                      out_map[l].kind == aom_pkg::K_D1;
      end
    end

    assign reg_sel = ctrl_q[g][aom_pkg::CB_SEL_BIT]; // [RQ19]
    assign reg_wr  = ctrl_q[g][aom_pkg::CB_WR_BIT];
    assign reg_num = ctrl_q[g][aom_pkg::CB_NUM_MSB:0];
    assign ow      = {d1_q[g], d0_q[g]};

    always_comb begin
      unique case (reg_num)
        aom_pkg::REG_FEATURE:  reg_rd = feat_q[g];
        aom_pkg::REG_OFFSET:   reg_rd = offs_q[g];
        aom_pkg::REG_GAIN:     reg_rd = gain_q[g];
        aom_pkg::REG_ACTIVATE: reg_rd = act_q[g];
        default:               reg_rd = 16'h0000;
      endcase
    end

    // image bytes written by the coupler
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ctrl_q[g]  <= 8'h00;
        d0_q[g]    <= 8'h00;
        d1_q[g]    <= 8'h00;
        touch_q[g] <= 1'b0;
      end else begin
        for (int l = 0; l < 2; l++) begin
          if (hit_ctrl[l]) begin
            ctrl_q[g] <= img_req.wdata[8*l +: 8];
          end
          if (hit_d0[l]) begin
            d0_q[g] <= img_req.wdata[8*l +: 8]; // [RQ14]
          end
          if (hit_d1[l]) begin
            d1_q[g] <= img_req.wdata[8*l +: 8];
          end
        end
        touch_q[g] <= |{hit_ctrl, hit_d0, hit_d1};
      end
    end

    // register writes act one cycle after the channel's bytes land, so ctrl and data agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        feat_q[g] <= aom_pkg::FEATURE_RST; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6]
        offs_q[g] <= aom_pkg::OFFSET_RST;  // [RQ7]
        gain_q[g] <= aom_pkg::GAIN_RST;    // [RQ8]
        act_q[g]  <= aom_pkg::ACTIVATE_RST; // [RQ9]
      end else if (touch_q[g] && reg_sel && reg_wr) begin // [RQ19]
        unique case (reg_num)
          aom_pkg::REG_FEATURE:  feat_q[g] <= ow & aom_pkg::FEATURE_MASK;
          aom_pkg::REG_OFFSET:   offs_q[g] <= ow;
          aom_pkg::REG_GAIN:     gain_q[g] <= ow;
          aom_pkg::REG_ACTIVATE: act_q[g]  <= ow;
          default:               ;
        endcase
      end
    end

    // status echo and input word; value holds while register access owns the channel
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        status_q[g] <= 8'h00;
        din_q[g]    <= 16'h0000;
        value_q[g]  <= 16'h0000;
      end else begin
        status_q[g] <= reg_sel ? {1'b1, reg_wr, reg_num} : 8'h00; // [RQ20]
        din_q[g]    <= (reg_sel && !reg_wr) ? reg_rd : 16'h0000;  // [RQ11]
        if (!reg_sel) begin
          value_q[g] <= ow; // [RQ11]
        end
      end
    end

    always_comb begin
      chan_cfg[g].value      = value_q[g];
      chan_cfg[g].offset     = offs_q[g];
      chan_cfg[g].gain       = gain_q[g];
      chan_cfg[g].activation = act_q[g];
      chan_cfg[g].user_scale = feat_q[g][aom_pkg::FB_USER_SCALE]; // [RQ1]
      chan_cfg[g].mfr_scale  = feat_q[g][aom_pkg::FB_MFR_SCALE];  // [RQ2]
      chan_cfg[g].wdog_run   = feat_q[g][aom_pkg::FB_WDOG_RUN];   // [RQ3]
      chan_cfg[g].sign_mag   = feat_q[g][aom_pkg::FB_SIGN_MAG];   // [RQ4]
      chan_cfg[g].twos_comp  = feat_q[g][aom_pkg::FB_TWOS_COMP];  // [RQ5]
      chan_cfg[g].use_act    = feat_q[g][aom_pkg::FB_USE_ACT];    // [RQ6]
    end
  end

  // ==========================================================================
  // input image read, one cycle latency
  logic [15:0] next_rdata;

  always_comb begin
    int idx;
    idx        = 0;
    next_rdata = 16'h0000;
    for (int l = 0; l < 2; l++) begin
      idx = int'(img_req.term) * aom_pkg::CH_PER_TERM + int'(in_map[l].ch);
      if (in_map[l].hit && idx < NCH) begin // [RQ16] [RQ18]
        unique case (in_map[l].kind)
          aom_pkg::K_CTRL: next_rdata[8*l +: 8] = status_q[idx];
          aom_pkg::K_D0:   next_rdata[8*l +: 8] = din_q[idx][7:0];
          aom_pkg::K_D1:   next_rdata[8*l +: 8] = din_q[idx][15:8];
          default:         next_rdata[8*l +: 8] = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      img_rdata  <= 16'h0000;
      img_rvalid <= 1'b0;
    end else begin
      img_rvalid <= img_req.rd;
      if (img_req.rd) begin
        img_rdata <= next_rdata;
      end
    end
  end

  // ==========================================================================
  // checks on channel 0, plus the unaligned control byte of channel 1
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_gain_write;
    touch_q[0] && ctrl_q[0][7] && ctrl_q[0][6] && ctrl_q[0][5:0] == aom_pkg::REG_GAIN;
  endsequence

  sequence s_compact_word0;
    img_req.wr && img_req.be == 2'b11 && img_req.addr == 3'd0 && !img_req.term &&
      !layout.complete;
  endsequence

  chk_feature_default: assert property ($rose(rst_n) |-> // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6]
      feat_q[0] == aom_pkg::FEATURE_RST && chan_cfg[0].mfr_scale && !chan_cfg[0].use_act)
    else $error("feature bits not at default after reset");

  chk_param_default: assert property ($rose(rst_n) |-> // [RQ7] [RQ8] [RQ9]
      chan_cfg[0].offset == 16'h0000 && chan_cfg[0].gain == 16'h0100 &&
      chan_cfg[0].activation == 16'h0000)
    else $error("parameter registers not at default after reset");

  chk_gain_write: assert property (s_gain_write |=> // [RQ19]
      chan_cfg[0].gain == $past({d1_q[0], d0_q[0]}))
    else $error("register write did not reach gain");

  chk_status_echo: assert property (ctrl_q[0][7] |=> // [RQ20]
      status_q[0] == {1'b1, $past(ctrl_q[0][6:0])})
    else $error("status byte did not echo register access");

  chk_pd_value: assert property (!ctrl_q[0][7] |=> // [RQ11]
      chan_cfg[0].value == $past({d1_q[0], d0_q[0]}) && din_q[0] == 16'h0000)
    else $error("process data value not taken or input word used");

  chk_compact_no_input: assert property (img_req.rd && !layout.complete |=> // [RQ13]
      img_rvalid && img_rdata == 16'h0000)
    else $error("compact layout returned input data");

  chk_byte_swap: assert property (s_compact_word0 |=> // [RQ14]
      {d1_q[0], d0_q[0]} == ($past(layout.big_endian) ?
        {$past(img_req.wdata[7:0]), $past(img_req.wdata[15:8])} : $past(img_req.wdata)))
    else $error("byte order wrong in compact layout");

  chk_pad_ignored: assert property (img_req.wr && layout.complete && layout.word_align && // [RQ18]
      img_req.addr == 3'd0 && img_req.be == 2'b10 |=> $stable(ctrl_q[0]) && $stable(d0_q[0]))
    else $error("pad byte write changed channel state");

  chk_unaligned_ctrl: assert property (img_req.wr && img_req.addr == 3'd1 && // [RQ15]
      img_req.be == 2'b10 && !img_req.term && layout.complete && !layout.word_align
      |=> ctrl_q[1] == $past(img_req.wdata[15:8]))
    else $error("second control byte not at word 1 high byte");

  // ==========================================================================
  // read path, feature masking and value hold on channel 0
  sequence s_feature_write;
    touch_q[0] && ctrl_q[0][7] && ctrl_q[0][6] && ctrl_q[0][5:0] == aom_pkg::REG_FEATURE;
  endsequence

  sequence s_aligned_word0_read;
    img_req.rd && !img_req.term && layout.complete && layout.word_align &&
      img_req.addr == 3'd0;
  endsequence

  // reserved feature bits must never be stored, whatever the coupler sends
  chk_feature_mask: assert property (s_feature_write |=> // [RQ1] [RQ4] [RQ5] [RQ6]
      feat_q[0] == ($past({d1_q[0], d0_q[0]}) & aom_pkg::FEATURE_MASK))
    else $error("feature write not masked to the defined bits");

  chk_status_read: assert property (s_aligned_word0_read |=> // [RQ16] [RQ18]
      img_rvalid && img_rdata == {8'h00, $past(status_q[0])})
    else $error("status byte not read at the control position");

  chk_value_hold: assert property (ctrl_q[0][7] |=> $stable(chan_cfg[0].value)) // [RQ19]
    else $error("value moved while register access owns the channel");

  chk_compact_no_ctrl: assert property (img_req.wr && !layout.complete |=> // [RQ13]
      $stable(ctrl_q[0]) && $stable(status_q[0]))
    else $error("compact write reached a control byte");

  chk_unmapped_read: assert property (ctrl_q[0][7:6] == 2'b10 && ctrl_q[0][5:0] == 6'h05 // [RQ19]
      |=> din_q[0] == 16'h0000)
    else $error("unmapped register number read nonzero");

endmodule

/* File: verification/aom_coupler_model.sv */
// coupler model: makes word writes and reads on the process image of the mapper
// assumes clk_sys runs freely and the mapper is out of reset before a task is called
`timescale 1ns/1ps
module aom_coupler_model (
  input  wire logic                  clk_sys,
  output aom_pkg::aom_img_req_t      img_req,
  input  wire logic [15:0]           img_rdata,
  input  wire logic                  img_rvalid
);
  initial img_req = '0;

  // ==========================================================================
  // word write; the data lines turn to junk once the strobe drops
  task automatic write_word(input logic t, input logic [2:0] a, input logic [1:0] be,
                            input logic [15:0] d);
    @(posedge clk_sys);
    img_req.wr    <= 1'b1;
    img_req.term  <= t;
    img_req.addr  <= a;
    img_req.be    <= be;
    img_req.wdata <= d;
    @(posedge clk_sys);
    img_req.wr    <= 1'b0;
    img_req.wdata <= ~d;
  endtask

  // ==========================================================================
  // word read; answer and strobe are sampled once settled after the second edge, the strobe again after the third
  task automatic read_word(input logic t, input logic [2:0] a, output logic [15:0] d,
                           output logic v1, output logic v2);
    @(posedge clk_sys);
    img_req.rd   <= 1'b1;
    img_req.term <= t;
    img_req.addr <= a;
    @(posedge clk_sys);
    img_req.rd <= 1'b0;
    #1;
    d  = img_rdata;
    v1 = img_rvalid;
    @(posedge clk_sys);
    #1;
    v2 = img_rvalid;
  endtask
endmodule

/* File: verification/test_aom_mapper.sv */
// self-checking bench for the process-image mapper, eight-channel build
// assumes the coupler model drives all image accesses; layout changes only under reset
`timescale 1ns/1ps
module test_aom_mapper;
  logic                   clk_sys;
  logic                   arst_n;
  aom_pkg::aom_layout_t   layout;
  aom_pkg::aom_img_req_t  img_req;
  logic [15:0]            img_rdata;
  logic                   img_rvalid;
  aom_pkg::aom_chan_cfg_t chan_cfg [8];
  int                     errors;
  int                     samples_checked;
  int                     cycles = 0;
  logic [15:0]            rd;
  logic                   v1;
  logic                   v2;
  logic [41:0]            row;
  logic [5:0]             rn;
  // {layout, addr, be, wdata, channel, expected value}
  localparam logic [41:0] ROWS [8] = '{
    {3'h0, 3'h2, 2'h3, 16'h1234, 2'h2, 16'h1234},
    {3'h2, 3'h0, 2'h3, 16'h1234, 2'h0, 16'h3412},
    {3'h4, 3'h2, 2'h3, 16'hABCD, 2'h1, 16'hABCD},
    {3'h6, 3'h2, 2'h3, 16'hABCD, 2'h1, 16'hCDAB},
    {3'h4, 3'h1, 2'h1, 16'h00EE, 2'h0, 16'hEE00},
    {3'h6, 3'h0, 2'h2, 16'h7700, 2'h0, 16'h7700},
    {3'h5, 3'h3, 2'h3, 16'h5678, 2'h1, 16'h5678},
    {3'h7, 3'h7, 2'h3, 16'h5678, 2'h3, 16'h7856}};
  localparam logic [15:0] RST [4] = '{16'h0006, 16'h0000, 16'h0100, 16'h0000};
  localparam logic [15:0] PAT [4] = '{16'hFFF9, 16'h8001, 16'h0200, 16'h7FFE};

  aom_mapper #(.N_TERM(2)) i_aom_mapper (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .layout     (layout),
    .img_req    (img_req),
    .img_rdata  (img_rdata),
    .img_rvalid (img_rvalid),
    .chan_cfg   (chan_cfg)
  );

  aom_coupler_model i_aom_coupler_model (
    .clk_sys    (clk_sys),
    .img_req    (img_req),
    .img_rdata  (img_rdata),
    .img_rvalid (img_rvalid)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // layout is only moved while the mapper is held in reset
  task automatic do_reset(input aom_pkg::aom_layout_t l);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    layout <= l;
    tick(3);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    tick(3);
  endtask

  task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
    i_aom_coupler_model.write_word(1'b0, a, be, d);
  endtask

  task automatic rd_w(input logic [2:0] a);
    i_aom_coupler_model.read_word(1'b0, a, rd, v1, v2);
    check("read strobe", {14'h0000, v1, v2}, 16'h0002);
  endtask

  function automatic logic [15:0] flags(input int c);
    return {10'h000, chan_cfg[c].user_scale, chan_cfg[c].mfr_scale, chan_cfg[c].wdog_run,
            chan_cfg[c].sign_mag, chan_cfg[c].twos_comp, chan_cfg[c].use_act};
  endfunction

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    errors = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    layout = '0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    tick(3);
    for (int c = 0; c < 8; c++) begin
      check("flags", flags(c), 16'h0018);
      check("offset", chan_cfg[c].offset, 16'h0000);
      check("gain", chan_cfg[c].gain, 16'h0100);
      check("activation", chan_cfg[c].activation, 16'h0000);
    end
    for (int r = 0; r < 8; r++) begin
      row = ROWS[r];
      do_reset(row[41:39]);
      wr(row[38:36], row[35:34], row[33:18]);
      tick(2);
      check("value", chan_cfg[row[17:16]].value, row[15:0]);
      rd_w(row[38:36]);
      check("input word", rd, 16'h0000);
    end
    // second terminal of the eight-channel build
    do_reset(3'h0);
    i_aom_coupler_model.write_word(1'b1, 3'h0, 2'h3, 16'h4321);
    wr(3'h4, 2'h3, 16'hFFFF);
    tick(2);
    check("term value", chan_cfg[4].value, 16'h4321);
    check("first value", chan_cfg[0].value, 16'h0000);
    // words past the twelve image bytes are dropped
    do_reset(3'h4);
    // channel 1 left reading its gain, to see the unaligned input map
    wr(3'h1, 2'h2, 16'hA200);
    wr(3'h6, 2'h3, 16'hFFFF);
    wr(3'h7, 2'h3, 16'hFFFF);
    tick(2);
    for (int c = 0; c < 4; c++) check("beyond image", chan_cfg[c].value, 16'h0000);
    rd_w(3'h6);
    check("beyond read", rd, 16'h0000);
    rd_w(3'h1);
    check("unaligned status", rd, 16'hA200);
    rd_w(3'h2);
    check("unaligned gain read", rd, 16'h0100);
    // register access on channel 0 in the aligned layout, where the checks watch
    do_reset(3'h5);
    for (int r = 0; r < 4; r++) begin
      rn = aom_pkg::REG_FEATURE + 6'(r);
      wr(3'h0, 2'h1, {8'h00, 2'h2, rn});
      rd_w(3'h0);
      check("status", rd, {8'h00, 2'h2, rn});
      rd_w(3'h1);
      check("reg reset", rd, RST[r]);
      wr(3'h0, 2'h1, {8'h00, 2'h3, rn});
      wr(3'h1, 2'h3, PAT[r]);
      wr(3'h0, 2'h1, {8'h00, 2'h2, rn});
      rd_w(3'h1);
      check("reg back", rd, (r == 0) ? 16'h0129 : PAT[r]);
    end
    check("flags set", flags(0), 16'h0027);
    check("offset set", chan_cfg[0].offset, 16'h8001);
    check("gain set", chan_cfg[0].gain, 16'h0200);
    check("act set", chan_cfg[0].activation, 16'h7FFE);
    check("value held", chan_cfg[0].value, 16'h0000);
    check("other gain", chan_cfg[1].gain, 16'h0100);
    wr(3'h0, 2'h2, 16'hFF00);
    rd_w(3'h0);
    check("pad", rd, 16'h00A3);
    wr(3'h0, 2'h1, 16'h00C5);
    wr(3'h1, 2'h3, 16'h1234);
    wr(3'h0, 2'h1, 16'h0085);
    rd_w(3'h1);
    check("unmapped reg", rd, 16'h0000);
    check("gain kept", chan_cfg[0].gain, 16'h0200);
    wr(3'h0, 2'h1, 16'h0000);
    wr(3'h1, 2'h3, 16'h2468);
    tick(2);
    check("process value", chan_cfg[0].value, 16'h2468);
    rd_w(3'h0);
    check("process status", rd, 16'h0000);
    // mid-run reset brings the parameters back
    do_reset(3'h5);
    check("gain again", chan_cfg[0].gain, 16'h0100);
    check("flags again", flags(0), 16'h0018);
    finish_test();
  end
endmodule
